// *** pkg/line_sync_perf_monitor_params.svh ***
// Constants for the line sync performance monitor
`ifndef LINE_SYNC_PERF_MONITOR_PARAMS_SVH
`define LINE_SYNC_PERF_MONITOR_PARAMS_SVH
`define CLK_HZ 25000000
`define CHECK_POLY 6'h03
`define CHECK_WIDTH 6
`define DECLARE_FRAMES 2'h3
`define CLEAR_FRAMES 2'h2
`define TICK_MS 100
`define TICK_CYCLES_DEFAULT ((`CLK_HZ / 1000) * `TICK_MS)
`define FAIL_DECLARE_TICKS 8'h19
`define FAIL_HOLD_TICKS 8'h14
`define FAIL_CLEAR_TICKS 8'h0A
`define ADDR_CTRL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_MASK 12'h008
`define ADDR_LIVE 12'h00C
`define ADDR_CV 12'h010
`define ADDR_ATTN_TH 12'h014
`define ADDR_SNR_TH 12'h018
`define ADDR_TICK_DIV 12'h01C
`define ADDR_CHK_RX 12'h020
`define BIT_CTRL_SYNC 0
`define BIT_CTRL_CVCLR 1
`define N_EVENTS 8
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// *** pkg/line_sync_perf_monitor_pkg.sv ***
// Types for the line sync performance monitor
package line_sync_perf_monitor_pkg;
  typedef enum logic {MODE_PLESIO, MODE_SYNC} sync_mode_t;
  typedef enum logic [1:0] {FAIL_IDLE, FAIL_PENDING, FAIL_ACTIVE, FAIL_CLEARING} fail_state_t;
endpackage : line_sync_perf_monitor_pkg

// *** rtl/frame_check_crc6.sv ***
// Serial 6-bit frame check code over the covered frame bits
`timescale 1ns/1ps
`default_nettype none
`include "line_sync_perf_monitor_params.svh"
module frame_check_crc6 (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  output logic [5:0] crc_out
);
  logic [5:0] crc_reg;
  wire feedback = crc_reg[5] ^ bit_in;
  // Remainder of m(D)*D^6 mod (D^6+D+1), first bit into the top
  wire [5:0] crc_shift = {crc_reg[4:0], 1'b0} ^ (feedback ? `CHECK_POLY : 6'h00);
  always_ff @(posedge clk_in) begin
    if (srst_in || start_in) begin
      crc_reg <= 6'h00;
    end else if (bit_valid_in) begin
      crc_reg <= crc_shift;
    end
  end
  assign crc_out = crc_reg;
endmodule : frame_check_crc6
`default_nettype wire

// *** rtl/frame_run_counter.sv ***
// Counts consecutive frames of a given kind, saturating
`timescale 1ns/1ps
`default_nettype none
module frame_run_counter (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic frame_in,
  input wire logic hit_in,
  output logic [1:0] run_out
);
  logic [1:0] run_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      run_reg <= 2'h0;
    end else if (frame_in) begin
      run_reg <= !hit_in ? 2'h0 : (run_reg == 2'h3 ? 2'h3 : run_reg + 2'h1);
    end
  end
  assign run_out = run_reg;
endmodule : frame_run_counter
`default_nettype wire

// *** rtl/line_sync_perf_monitor.sv ***
// Receive-side sync-loss, check-code and defect monitor with AXI4-Lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "line_sync_perf_monitor_params.svh"
module line_sync_perf_monitor (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic frame_start_in,
  input wire logic cov_bit_valid_in,
  input wire logic cov_bit_in,
  input wire logic frame_end_in,
  input wire logic [5:0] frame_check_bits_in,
  input wire logic framing_err_in,
  input wire logic sync_word_err_in,
  input wire logic regen_mode_in,
  input wire logic dir_upstream_in,
  input wire logic regen_sync_loss_up_in,
  input wire logic regen_sync_loss_dn_in,
  input wire logic [7:0] loop_attn_in,
  input wire logic [7:0] snr_margin_in,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic check_anomaly_out,
  output logic sega_up_out,
  output logic sega_dn_out,
  output logic sync_word_loss_out,
  output logic segd_up_out,
  output logic segd_dn_out,
  output logic attn_defect_out,
  output logic snr_defect_out,
  output logic sync_loss_failure_out,
  output logic irq_out
);
  import line_sync_perf_monitor_pkg::*;

  // Control, threshold, status, counter and received-code registers
  logic ctrl_mode_reg;
  logic [7:0] attn_th_reg;
  logic [7:0] snr_th_reg;
  logic [31:0] tick_div_reg;
  logic [`N_EVENTS-1:0] status_reg;
  logic [`N_EVENTS-1:0] mask_reg;
  logic [31:0] cv_reg;
  logic [5:0] chk_rx_reg;

  // Check code path
  logic [5:0] crc_calc;
  frame_check_crc6 u_crc (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .start_in(frame_start_in),
    .bit_valid_in(cov_bit_valid_in),
    .bit_in(cov_bit_in),
    .crc_out(crc_calc)
  );
  // The code of one frame travels in the next, so compare at the next frame end
  logic [5:0] crc_prev_reg;
  logic crc_prev_valid_reg;
  wire anomaly_now = frame_end_in && crc_prev_valid_reg && (crc_prev_reg != frame_check_bits_in);
  logic anomaly_reg;
  logic sega_up_reg;
  logic sega_dn_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      crc_prev_reg <= 6'h00;
      crc_prev_valid_reg <= 1'b0;
      anomaly_reg <= 1'b0;
      sega_up_reg <= 1'b0;
      sega_dn_reg <= 1'b0;
      chk_rx_reg <= 6'h00;
    end else begin
      anomaly_reg <= anomaly_now;
      sega_up_reg <= anomaly_now && regen_mode_in && dir_upstream_in;
      sega_dn_reg <= anomaly_now && regen_mode_in && !dir_upstream_in;
      if (frame_end_in) begin
        crc_prev_reg <= crc_calc;
        crc_prev_valid_reg <= 1'b1;
        chk_rx_reg <= frame_check_bits_in;
      end
    end
  end

  // Sync-loss defect
  wire frame_bad = (ctrl_mode_reg == MODE_SYNC) ? sync_word_err_in : framing_err_in;
  logic [1:0] bad_run;
  logic [1:0] good_run;
  frame_run_counter u_bad (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .frame_in(frame_end_in),
    .hit_in(frame_bad),
    .run_out(bad_run)
  );
  frame_run_counter u_good (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .frame_in(frame_end_in),
    .hit_in(!frame_bad),
    .run_out(good_run)
  );
  logic sync_word_loss_reg;
  // Same thresholds in both modes; the mode only picks which bits count as errors
  wire sync_word_loss_set = frame_end_in && frame_bad && (bad_run >= `DECLARE_FRAMES - 2'h1);
  wire sync_word_loss_clr = frame_end_in && !frame_bad && (good_run >= `CLEAR_FRAMES - 2'h1);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_word_loss_reg <= 1'b0;
    end else if (sync_word_loss_set) begin
      sync_word_loss_reg <= 1'b1;
    end else if (sync_word_loss_clr) begin
      sync_word_loss_reg <= 1'b0;
    end
  end

  // Segment defects follow the regenerator sync-loss inputs, ORed in regen mode with sync_word_loss on the dir_upstream_in side
  logic [1:0] segd_reg;
  wire segd_up_next = (regen_mode_in && dir_upstream_in && sync_word_loss_reg) || regen_sync_loss_up_in;
  wire segd_dn_next = (regen_mode_in && !dir_upstream_in && sync_word_loss_reg) || regen_sync_loss_dn_in;
  logic attn_reg;
  logic snr_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      segd_reg <= 2'h0;
      attn_reg <= 1'b0;
      snr_reg <= 1'b0;
    end else begin
      segd_reg <= {segd_dn_next, segd_up_next};
      attn_reg <= loop_attn_in > attn_th_reg;
      snr_reg <= snr_margin_in < snr_th_reg;
    end
  end

  // Tick divider counts up, so a shorter period written by software applies at once
  logic [31:0] tick_cnt_reg;
  wire tick = (tick_cnt_reg >= tick_div_reg);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  // Failure timing in ticks: declare after 2.5 s, hold 2 s, clear 1 s after defect ends
  fail_state_t fail_state_reg;
  logic [7:0] fail_cnt_reg;
  logic fail_reg;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fail_state_reg <= FAIL_IDLE;
      fail_cnt_reg <= 8'h00;
      fail_reg <= 1'b0;
    end else begin
      unique case (fail_state_reg)
        FAIL_IDLE: begin
          fail_cnt_reg <= 8'h00;
          if (sync_word_loss_reg) begin
            fail_state_reg <= FAIL_PENDING;
          end
        end
        FAIL_PENDING: begin
          if (!sync_word_loss_reg) begin
            fail_state_reg <= FAIL_IDLE;
          end else if (tick) begin
            if (fail_cnt_reg + 8'h01 >= `FAIL_DECLARE_TICKS) begin
              fail_state_reg <= FAIL_ACTIVE;
              fail_reg <= 1'b1;
              fail_cnt_reg <= 8'h00;
            end else begin
              fail_cnt_reg <= fail_cnt_reg + 8'h01;
            end
          end
        end
        FAIL_ACTIVE: begin
          if (tick && fail_cnt_reg < `FAIL_HOLD_TICKS) begin
            fail_cnt_reg <= fail_cnt_reg + 8'h01;
          end
          if (fail_cnt_reg >= `FAIL_HOLD_TICKS && !sync_word_loss_reg) begin
            fail_state_reg <= FAIL_CLEARING;
            fail_cnt_reg <= 8'h00;
          end
        end
        FAIL_CLEARING: begin
          if (sync_word_loss_reg) begin
            fail_state_reg <= FAIL_ACTIVE;
            fail_cnt_reg <= `FAIL_HOLD_TICKS;
          end else if (tick) begin
            if (fail_cnt_reg + 8'h01 >= `FAIL_CLEAR_TICKS) begin
              fail_state_reg <= FAIL_IDLE;
              fail_reg <= 1'b0;
            end else begin
              fail_cnt_reg <= fail_cnt_reg + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // Interrupt events: anomaly, sega up/dn, sync_word_loss rise, segd rise, attn rise, snr rise, failure rise
  logic [`N_EVENTS-1:0] live_prev_reg;
  wire [`N_EVENTS-1:0] live = {fail_reg, snr_reg, attn_reg, |segd_reg, sync_word_loss_reg, sega_dn_reg, sega_up_reg, anomaly_reg};
  wire [`N_EVENTS-1:0] events = live & ~live_prev_reg;

  // AXI4-Lite slave: write address and data taken in either order
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  wire aw_have = aw_held_reg || (s_axi_awvalid && s_axi_awready);
  wire w_have = w_held_reg || (s_axi_wvalid && s_axi_wready);
  wire [11:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire wr_fire = aw_have && w_have && !bvalid_reg;
  wire wr_map = (wr_addr == `ADDR_CTRL) || (wr_addr == `ADDR_MASK) || (wr_addr == `ADDR_ATTN_TH) ||
                (wr_addr == `ADDR_SNR_TH) || (wr_addr == `ADDR_TICK_DIV);
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire rd_status = rd_fire && (s_axi_araddr == `ADDR_STATUS);
  wire cv_clear = wr_fire && (wr_addr == `ADDR_CTRL) && wr_strb[0] && wr_data[`BIT_CTRL_CVCLR];
  logic [31:0] rd_value;
  logic rd_ok;
  always_comb begin
    rd_value = 32'h0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ADDR_CTRL: rd_value = {31'h0, ctrl_mode_reg};
      `ADDR_STATUS: rd_value = {24'h0, status_reg};
      `ADDR_MASK: rd_value = {24'h0, mask_reg};
      `ADDR_LIVE: rd_value = {24'h0, fail_reg, snr_reg, attn_reg, segd_reg[1], segd_reg[0], sync_word_loss_reg, 2'h0};
      `ADDR_CV: rd_value = cv_reg;
      `ADDR_ATTN_TH: rd_value = {24'h0, attn_th_reg};
      `ADDR_SNR_TH: rd_value = {24'h0, snr_th_reg};
      `ADDR_TICK_DIV: rd_value = tick_div_reg;
      `ADDR_CHK_RX: rd_value = {26'h0, chk_rx_reg};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `AXI_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_map ? `AXI_OKAY : `AXI_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `AXI_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_ok ? `AXI_OKAY : `AXI_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Register writes, status and counter
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_mode_reg <= MODE_PLESIO;
      mask_reg <= 8'h00;
      attn_th_reg <= 8'hFF;
      snr_th_reg <= 8'h00;
      tick_div_reg <= 32'(`TICK_CYCLES_DEFAULT - 1);
      status_reg <= 8'h00;
      live_prev_reg <= 8'h00;
      cv_reg <= 32'h0;
    end else begin
      live_prev_reg <= live;
      // Set wins over the read-clear
      status_reg <= (rd_status ? 8'h00 : status_reg) | events;
      // An anomaly in the clearing cycle is counted from zero
      if (cv_clear) begin
        cv_reg <= {31'h0, anomaly_reg};
      end else if (anomaly_reg) begin
        cv_reg <= cv_reg + 32'h1;
      end
      if (wr_fire && wr_strb[0]) begin
        if (wr_addr == `ADDR_CTRL) begin
          ctrl_mode_reg <= sync_mode_t'(wr_data[`BIT_CTRL_SYNC]);
        end
        if (wr_addr == `ADDR_MASK) begin
          mask_reg <= wr_data[7:0];
        end
        if (wr_addr == `ADDR_ATTN_TH) begin
          attn_th_reg <= wr_data[7:0];
        end
        if (wr_addr == `ADDR_SNR_TH) begin
          snr_th_reg <= wr_data[7:0];
        end
      end
      if (wr_fire && wr_addr == `ADDR_TICK_DIV) begin
        tick_div_reg <= {wr_strb[3] ? wr_data[31:24] : tick_div_reg[31:24],
                         wr_strb[2] ? wr_data[23:16] : tick_div_reg[23:16],
                         wr_strb[1] ? wr_data[15:8] : tick_div_reg[15:8],
                         wr_strb[0] ? wr_data[7:0] : tick_div_reg[7:0]};
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign check_anomaly_out = anomaly_reg;
  assign sega_up_out = sega_up_reg;
  assign sega_dn_out = sega_dn_reg;
  assign sync_word_loss_out = sync_word_loss_reg;
  assign segd_up_out = segd_reg[0];
  assign segd_dn_out = segd_reg[1];
  assign attn_defect_out = attn_reg;
  assign snr_defect_out = snr_reg;
  assign sync_loss_failure_out = fail_reg;
  assign irq_out = |(status_reg & mask_reg);
endmodule : line_sync_perf_monitor
`default_nettype wire

// *** verification/line_sync_perf_monitor_properties.sv ***
// Concurrent checks on the line sync performance monitor ports
`timescale 1ns/1ps
`default_nettype none
module line_sync_perf_monitor_properties #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic frame_end_in,
  input wire logic framing_err_in,
  input wire logic sync_word_err_in,
  input wire logic regen_mode_in,
  input wire logic dir_upstream_in,
  input wire logic regen_sync_loss_up_in,
  input wire logic regen_sync_loss_dn_in,
  input wire logic check_anomaly_out,
  input wire logic sega_up_out,
  input wire logic sega_dn_out,
  input wire logic sync_word_loss_out,
  input wire logic segd_up_out,
  input wire logic segd_dn_out,
  input wire logic sync_loss_failure_out
);
  // Tick phase is unknown here, so the 2 s floor gives away one tick
  localparam int MIN_2S = 19 * TICK_CYCLES;
  logic [15:0] sync_word_loss_run;
  logic [15:0] fail_run;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sync_word_loss_run <= 16'h0000;
      fail_run <= 16'h0000;
    end else begin
      sync_word_loss_run <= sync_word_loss_out ? sync_word_loss_run + 16'h0001 : 16'h0000;
      fail_run <= sync_loss_failure_out ? fail_run + 16'h0001 : 16'h0000;
    end
  end
  a_anomaly_cause: assert property (check_anomaly_out |-> $past(frame_end_in))
    else $error("anomaly without a frame end");
  a_sega_up_dir: assert property (sega_up_out |-> check_anomaly_out && $past(regen_mode_in) && $past(dir_upstream_in))
    else $error("upstream segment anomaly without cause");
  a_sega_dn_dir: assert property (sega_dn_out |-> check_anomaly_out && $past(regen_mode_in) && !$past(dir_upstream_in))
    else $error("downstream segment anomaly without cause");
  a_segd_follows_ext: assert property (regen_sync_loss_dn_in |=> segd_dn_out)
    else $error("downstream segment defect missed");
  a_segd_release: assert property ($fell(segd_up_out) |-> !$past(regen_sync_loss_up_in))
    else $error("segment defect cleared while a regenerator lost sync");
  a_sync_word_loss_rise_cause: assert property ($rose(sync_word_loss_out) |-> $past(frame_end_in) && ($past(framing_err_in) || $past(sync_word_err_in)))
    else $error("sync loss declared without an errored frame");
  a_sync_word_loss_fall_frame: assert property ($fell(sync_word_loss_out) |-> $past(frame_end_in))
    else $error("sync loss cleared away from a frame end");
  a_fail_declare_min: assert property ($rose(sync_loss_failure_out) |-> sync_word_loss_run >= 16'(MIN_2S))
    else $error("failure declared too early");
  a_fail_hold_min: assert property ($fell(sync_loss_failure_out) |-> fail_run >= 16'(MIN_2S))
    else $error("failure held too briefly");
  c_sega_up: cover property (sega_up_out);
  c_fail_rise: cover property ($rose(sync_loss_failure_out));
  c_segd_dn: cover property ($rose(segd_dn_out));
endmodule : line_sync_perf_monitor_properties
`default_nettype wire

// *** verification/far_end_frame_source.sv ***
// Far-end transmitter model that sends checked frames to the monitor
`timescale 1ns/1ps
`default_nettype none
module far_end_frame_source (
  input wire logic clk_in,
  output logic frame_start_out = 1'b0,
  output logic bit_valid_out = 1'b0,
  output logic bit_out = 1'b0,
  output logic frame_end_out = 1'b0,
  output logic [5:0] check_bits_out = 6'h00,
  output logic framing_err_out = 1'b0,
  output logic sync_err_out = 1'b0
);
  // The code of each frame rides on the frame after it
  logic [5:0] prev_code = 6'h00;
  task automatic send(input int nbits, input logic bad, input logic ferr, input logic serr);
    logic [5:0] code;
    logic b;
    code = 6'h00;
    b = 1'b0;
    @(posedge clk_in);
    frame_start_out <= 1'b1;
    for (int i = 0; i < nbits; i++) begin
      @(posedge clk_in);
      frame_start_out <= 1'b0;
      b = ((i * 5 + nbits) % 3) == 0;
      code = {code[4:0], 1'b0} ^ ((code[5] ^ b) ? 6'h03 : 6'h00);
      bit_valid_out <= 1'b1;
      bit_out <= b;
    end
    @(posedge clk_in);
    bit_valid_out <= 1'b0;
    bit_out <= ~b;
    frame_end_out <= 1'b1;
    check_bits_out <= prev_code ^ {5'h00, bad};
    framing_err_out <= ferr;
    sync_err_out <= serr;
    prev_code = code;
    @(posedge clk_in);
    frame_end_out <= 1'b0;
    check_bits_out <= ~check_bits_out;
    #1;
  endtask : send
endmodule : far_end_frame_source
`default_nettype wire

// *** verification/line_sync_perf_monitor_bench.sv ***
// Self-checking bench for the line sync performance monitor
`timescale 1ns/1ps
`default_nettype none
`include "line_sync_perf_monitor_params.svh"
module line_sync_perf_monitor_bench;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic frame_start_in, cov_bit_valid_in, cov_bit_in, frame_end_in, framing_err_in, sync_word_err_in;
  logic [5:0] frame_check_bits_in;
  logic regen_mode_in = 1'b0, dir_upstream_in = 1'b0, regen_sync_loss_up_in = 1'b0, regen_sync_loss_dn_in = 1'b0;
  logic [7:0] loop_attn_in = 8'h00, snr_margin_in = 8'h80;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic check_anomaly_out, sega_up_out, sega_dn_out, sync_word_loss_out, segd_up_out, segd_dn_out;
  logic attn_defect_out, snr_defect_out, sync_loss_failure_out, irq_out;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #20 clk_in = ~clk_in;
  far_end_frame_source i_far (.clk_in, .frame_start_out(frame_start_in), .bit_valid_out(cov_bit_valid_in),
    .bit_out(cov_bit_in), .frame_end_out(frame_end_in), .check_bits_out(frame_check_bits_in),
    .framing_err_out(framing_err_in), .sync_err_out(sync_word_err_in));
  line_sync_perf_monitor i_dut (.clk_in, .srst_in, .frame_start_in, .cov_bit_valid_in, .cov_bit_in, .frame_end_in,
    .frame_check_bits_in, .framing_err_in, .sync_word_err_in, .regen_mode_in, .dir_upstream_in,
    .regen_sync_loss_up_in, .regen_sync_loss_dn_in, .loop_attn_in, .snr_margin_in, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .check_anomaly_out, .sega_up_out, .sega_dn_out, .sync_word_loss_out, .segd_up_out, .segd_dn_out,
    .attn_defect_out, .snr_defect_out, .sync_loss_failure_out, .irq_out);
  function automatic logic [31:0] bit32(input logic b);
    return {31'h0, b};
  endfunction : bit32
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Bounds the whole run so a stuck handshake still reaches the verdict
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : step
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk_in);
      pa = pa && (s_axi_awready !== 1'b1);
      pw = pw && (s_axi_wready !== 1'b1);
      @(posedge clk_in);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    @(negedge clk_in);
    while (s_axi_bvalid !== 1'b1) @(negedge clk_in);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk_in);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge clk_in);
    while (s_axi_arready !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    s_axi_arvalid <= 1'b0;
    @(negedge clk_in);
    while (s_axi_rvalid !== 1'b1) @(negedge clk_in);
    chk(s_axi_rdata & m, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk_in);
    s_axi_rready <= 1'b0;
  endtask : rdchk
  task automatic test_regs;
    rdchk(`ADDR_CTRL, 32'h3, 32'h0, `AXI_OKAY);
    rdchk(`ADDR_ATTN_TH, 32'hFF, 32'hFF, `AXI_OKAY);
    rdchk(`ADDR_SNR_TH, 32'hFF, 32'h0, `AXI_OKAY);
    rdchk(`ADDR_TICK_DIV, 32'hFFFFFFFF, 32'h0026259F, `AXI_OKAY);
    rdchk(12'h040, 32'hFFFFFFFF, 32'h0, `AXI_SLVERR);
    axw(`ADDR_LIVE, 32'hFF, `AXI_SLVERR);
    axw(`ADDR_TICK_DIV, 32'h9, `AXI_OKAY);
    rdchk(`ADDR_TICK_DIV, 32'hFFFFFFFF, 32'h9, `AXI_OKAY);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_check;
    repeat (2) i_far.send(16, 1'b0, 1'b0, 1'b0);
    chk(bit32(check_anomaly_out), 32'h0);
    @(posedge clk_in);
    regen_mode_in <= 1'b1;
    dir_upstream_in <= 1'b1;
    i_far.send(16, 1'b1, 1'b0, 1'b0);
    chk({30'h0, sega_up_out, sega_dn_out}, 32'h2);
    @(posedge clk_in);
    dir_upstream_in <= 1'b0;
    i_far.send(12, 1'b1, 1'b0, 1'b0);
    chk({30'h0, sega_up_out, sega_dn_out}, 32'h1);
    @(posedge clk_in);
    regen_mode_in <= 1'b0;
    i_far.send(20, 1'b1, 1'b0, 1'b0);
    chk({29'h0, check_anomaly_out, sega_up_out, sega_dn_out}, 32'h4);
    chk(bit32(irq_out), 32'h0);
    rdchk(`ADDR_CV, 32'hFFFFFFFF, 32'h3, `AXI_OKAY);
    rdchk(`ADDR_STATUS, 32'h7, 32'h7, `AXI_OKAY);
    rdchk(`ADDR_STATUS, 32'h7, 32'h0, `AXI_OKAY);
    axw(`ADDR_MASK, 32'h1, `AXI_OKAY);
    i_far.send(8, 1'b1, 1'b0, 1'b0);
    step(2);
    chk(bit32(irq_out), 32'h1);
    rdchk(`ADDR_STATUS, 32'h1, 32'h1, `AXI_OKAY);
    step(1);
    chk(bit32(irq_out), 32'h0);
    axw(`ADDR_CTRL, 32'h2, `AXI_OKAY);
    rdchk(`ADDR_CV, 32'hFFFFFFFF, 32'h0, `AXI_OKAY);
    $display("test_check done");
  endtask : test_check
  task automatic test_sync_word_loss;
    for (int mi = 0; mi < 2; mi++) begin
      axw(`ADDR_CTRL, 32'(mi), `AXI_OKAY);
      repeat (2) i_far.send(8, 1'b0, mi == 0, mi == 1);
      chk(bit32(sync_word_loss_out), 32'h0);
      i_far.send(8, 1'b0, mi == 0, mi == 1);
      chk(bit32(sync_word_loss_out), 32'h1);
      i_far.send(8, 1'b0, 1'b0, 1'b0);
      chk(bit32(sync_word_loss_out), 32'h1);
      i_far.send(8, 1'b0, 1'b0, 1'b0);
      chk(bit32(sync_word_loss_out), 32'h0);
    end
    // Stuff-bit errors alone must not count in synchronous mode
    repeat (3) i_far.send(8, 1'b0, 1'b1, 1'b0);
    chk(bit32(sync_word_loss_out), 32'h0);
    $display("test_sync_word_loss done");
  endtask : test_sync_word_loss
  task automatic test_segd_thr;
    @(posedge clk_in);
    regen_sync_loss_up_in <= 1'b1;
    regen_sync_loss_dn_in <= 1'b1;
    step(2);
    chk({30'h0, segd_up_out, segd_dn_out}, 32'h3);
    @(posedge clk_in);
    regen_sync_loss_up_in <= 1'b0;
    step(2);
    chk({30'h0, segd_up_out, segd_dn_out}, 32'h1);
    @(posedge clk_in);
    regen_sync_loss_dn_in <= 1'b0;
    axw(`ADDR_ATTN_TH, 32'h40, `AXI_OKAY);
    axw(`ADDR_SNR_TH, 32'h20, `AXI_OKAY);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_in);
      loop_attn_in <= 8'h40 + 8'(k);
      snr_margin_in <= 8'h20 - 8'(k);
      step(2);
      chk({30'h0, attn_defect_out, snr_defect_out}, (k == 1) ? 32'h3 : 32'h0);
    end
    $display("test_segd_thr done");
  endtask : test_segd_thr
  task automatic test_fail;
    int c0;
    rdchk(`ADDR_STATUS, 32'hFF, 32'h78, `AXI_OKAY);
    repeat (3) i_far.send(8, 1'b0, 1'b0, 1'b1);
    c0 = cycles;
    while (sync_loss_failure_out !== 1'b1 && cycles - c0 < 400) step(1);
    chk(bit32(cycles - c0 >= 190 && cycles - c0 <= 310), 32'h1);
    rdchk(`ADDR_LIVE, 32'hFF, 32'hE4, `AXI_OKAY);
    c0 = cycles;
    repeat (2) i_far.send(8, 1'b0, 1'b0, 1'b0);
    while (sync_loss_failure_out === 1'b1 && cycles - c0 < 3000) step(1);
    chk(bit32(cycles - c0 >= 190 && cycles - c0 <= 2030), 32'h1);
    rdchk(`ADDR_STATUS, 32'hFF, 32'h88, `AXI_OKAY);
    $display("test_fail done");
  endtask : test_fail
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    test_regs();
    test_check();
    test_sync_word_loss();
    test_segd_thr();
    test_fail();
    finish_test();
  end
endmodule : line_sync_perf_monitor_bench
bind line_sync_perf_monitor line_sync_perf_monitor_properties #(.TICK_CYCLES(10)) u_props (.clk_in, .srst_in,
  .frame_end_in, .framing_err_in, .sync_word_err_in, .regen_mode_in, .dir_upstream_in, .regen_sync_loss_up_in,
  .regen_sync_loss_dn_in, .check_anomaly_out, .sega_up_out, .sega_dn_out, .sync_word_loss_out, .segd_up_out,
  .segd_dn_out, .sync_loss_failure_out);
`default_nettype wire
